// file: pfr_ctrl.sv
/*
 Programmable and recovery frequency control for a clock synthesizer.
 Holds the divider bytes written over the management byte port, picks the
 frequency words and ratio code for the synthesizer core, and locks into
 recovery mode after a watchdog timeout.
 Assumes a byte-level management slave outside that presents one decoded
 write per strobe, a watchdog outside that pulses on timeout, and strap
 codes already latched at power-on.
*/
`include "pfr_map.svh"

// How it works
// - Source bit picks strap or recovery words
// - Timeout switches to recovery without host
// - Source one uses recovery N/M words
// - Override bit picks strap or software ratio
// - Upper byte bit 7 enables custom frequency
// - Custom enable uses programmed N/M words
// - M word write starts frequency load
// - Source bit 7, recovery M bits 6-0
// - Recovery locks; arm bit clear unlocks
// - Recovery N word in preceding byte
module pfr_ctrl
(
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic srst_in,
	// Management byte port
	input wire logic wr_en_in,
	input wire pfr_pkg::pfr_wr_s wr_in,
	input wire logic [7:0] rd_index_in,
	output logic [7:0] rd_data_out,
	// Loose control bits
	input wire logic [4:0] latched_strap_ratio_code_in,
	input wire logic [4:0] sw_ratio_code_in,
	input wire logic ratio_source_override_in,
	input wire logic watchdog_arm_bit_in,
	input wire logic wd_timeout_in,
	// Synthesizer side
	output pfr_pkg::pfr_freq_s freq_out,
	output logic load_out,
	output logic recovery_mode_out
);
	import pfr_pkg::*;

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [7:0] recov_n_q, recov_n_d; // Recovery N divider word
	logic [7:0] recov_sm_q, recov_sm_d; // Source bit and recovery M
	logic [7:0] prog_n_q, prog_n_d; // Programmed N word
	logic [7:0] prog_em_q, prog_em_d; // Enable bit and programmed M
	pfr_mode_e mode_q, mode_d; // Normal or recovery lock
	logic load_q, load_d; // Load strobe to core
	pfr_freq_s freq_q, freq_d; // Registered selection
	logic [7:0] rd_q, rd_d; // Read data

	// Accepted frequency writes are blocked while locked
	logic freq_wr_ok;
	assign freq_wr_ok = wr_en_in && (mode_q == PFR_NORMAL);

	// ----------------------------------------
	// Byte register next values
	// ----------------------------------------
	always_comb
	begin
		recov_n_d = recov_n_q;
		recov_sm_d = recov_sm_q;
		prog_n_d = prog_n_q;
		prog_em_d = prog_em_q;
		// Recovery bytes stay writable; they only matter after a timeout
		if (wr_en_in)
		begin
			if (wr_in.index == `PFR_IDX_RECOV_N)
				recov_n_d = wr_in.data;
			if (wr_in.index == `PFR_IDX_RECOV_SRC_M)
				recov_sm_d = wr_in.data;
		end
		if (freq_wr_ok)
		begin
			if (wr_in.index == `PFR_IDX_PROG_N)
				prog_n_d = wr_in.data;
			if (wr_in.index == `PFR_IDX_PROG_EN_M)
				prog_em_d = wr_in.data;
		end
	end

	// ----------------------------------------
	// Mode and load strobe next values
	// ----------------------------------------
	always_comb
	begin
		mode_d = mode_q;
		load_d = 1'b0;
		case (mode_q)
			PFR_NORMAL:
			begin
				if (wd_timeout_in && watchdog_arm_bit_in)
				begin
					mode_d = PFR_RECOVERY;
					load_d = 1'b1;
				end
				else if (freq_wr_ok && wr_in.index == `PFR_IDX_PROG_EN_M)
					load_d = 1'b1;
			end
			PFR_RECOVERY:
			begin
				if (!watchdog_arm_bit_in)
				begin
					mode_d = PFR_NORMAL;
					load_d = 1'b1;
				end
			end
			default:
				mode_d = PFR_NORMAL;
		endcase
	end

	// ----------------------------------------
	// Frequency selection
	// ----------------------------------------
	always_comb
	begin
		freq_d = '0;
		freq_d.ratio_code = ratio_source_override_in ? sw_ratio_code_in
			: latched_strap_ratio_code_in;
		freq_d.freq_code = freq_d.ratio_code;
		if (mode_d == PFR_RECOVERY)
		begin
			if (recov_sm_d[`PFR_BIT_RECOV_SRC])
			begin
				freq_d.use_divider = 1'b1;
				freq_d.n_word = recov_n_d;
				freq_d.m_word = recov_sm_d[`PFR_M_MSB:0];
			end
			else
				freq_d.freq_code = latched_strap_ratio_code_in;
		end
		else if (prog_em_d[`PFR_BIT_CUSTOM_EN])
		begin
			freq_d.use_divider = 1'b1;
			freq_d.n_word = prog_n_d;
			freq_d.m_word = prog_em_d[`PFR_M_MSB:0];
		end
		// output frozen while locked
		// Recovery bytes stay writable, but a write must not move a locked output
		if (mode_q == PFR_RECOVERY && mode_d == PFR_RECOVERY)
			freq_d = freq_q;
	end

	// ----------------------------------------
	// Read data, unmapped indexes read zero
	// ----------------------------------------
	always_comb
	begin
		case (rd_index_in)
			`PFR_IDX_RECOV_N: rd_d = recov_n_q;
			`PFR_IDX_RECOV_SRC_M: rd_d = recov_sm_q;
			`PFR_IDX_PROG_N: rd_d = prog_n_q;
			`PFR_IDX_PROG_EN_M: rd_d = prog_em_q;
			default: rd_d = 8'h00;
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk_sys_in)
	begin
		if (srst_in)
		begin
			recov_n_q <= `PFR_RST_BYTE;
			recov_sm_q <= `PFR_RST_BYTE;
			prog_n_q <= `PFR_RST_BYTE;
			prog_em_q <= `PFR_RST_BYTE;
			mode_q <= PFR_NORMAL;
			load_q <= 1'b0;
			freq_q <= '0;
			rd_q <= 8'h00;
		end
		else
		begin
			recov_n_q <= recov_n_d;
			recov_sm_q <= recov_sm_d;
			prog_n_q <= prog_n_d;
			prog_em_q <= prog_em_d;
			mode_q <= mode_d;
			load_q <= load_d;
			freq_q <= freq_d;
			rd_q <= rd_d;
		end
	end

	assign freq_out = freq_q;
	assign load_out = load_q;
	assign recovery_mode_out = (mode_q == PFR_RECOVERY);
	assign rd_data_out = rd_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (srst_in);

	// Judged at entry, since the output is frozen afterwards
	property p_src_strap;
		($rose(recovery_mode_out) && !recov_sm_q[7])
			|-> !freq_q.use_divider
			&& freq_q.freq_code == $past(latched_strap_ratio_code_in);
	endproperty
	a_src_strap: assert property (p_src_strap) else $error("strap source not used");

	property p_timeout;
		(mode_q == PFR_NORMAL && wd_timeout_in && watchdog_arm_bit_in)
			|=> recovery_mode_out && load_out;
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout did not enter recovery");

	property p_recov_words;
		($rose(recovery_mode_out) && recov_sm_q[7])
			|-> freq_q.use_divider && freq_q.n_word == recov_n_q
			&& freq_q.m_word == recov_sm_q[6:0];
	endproperty
	a_recov_words: assert property (p_recov_words) else $error("recovery words wrong");

	property p_ratio;
		!(mode_q == PFR_RECOVERY && watchdog_arm_bit_in)
			|=> freq_q.ratio_code == ($past(ratio_source_override_in)
			? $past(sw_ratio_code_in) : $past(latched_strap_ratio_code_in));
	endproperty
	a_ratio: assert property (p_ratio) else $error("ratio code wrong");

	property p_prog_words;
		(mode_q == PFR_NORMAL && !wd_timeout_in && !wr_en_in && prog_em_q[7])
			|=> freq_q.use_divider && freq_q.n_word == prog_n_q
			&& freq_q.m_word == prog_em_q[6:0];
	endproperty
	a_prog_words: assert property (p_prog_words) else $error("programmed words wrong");

	property p_m_load;
		(freq_wr_ok && wr_in.index == 8'h0e) |=> load_out;
	endproperty
	a_m_load: assert property (p_m_load) else $error("M write gave no load");

	property p_lock;
		(mode_q == PFR_RECOVERY && wr_en_in && wr_in.index == 8'h0e)
			|=> $stable(prog_em_q);
	endproperty
	a_lock: assert property (p_lock) else $error("write changed locked frequency");

	property p_unlock;
		(mode_q == PFR_RECOVERY && !watchdog_arm_bit_in) |=> !recovery_mode_out;
	endproperty
	a_unlock: assert property (p_unlock) else $error("disarm did not unlock");

	property p_freq_hold;
		(mode_q == PFR_RECOVERY && watchdog_arm_bit_in) |=> $stable(freq_q);
	endproperty
	a_freq_hold: assert property (p_freq_hold) else $error("locked frequency changed");

	property p_n_only;
		(mode_q == PFR_NORMAL && !wd_timeout_in && wr_en_in && wr_in.index == 8'h0d)
			|=> !load_out;
	endproperty
	a_n_only: assert property (p_n_only) else $error("N write started a load");

endmodule : pfr_ctrl

// file: pfr_host_model.sv
/*
 Management host model: byte writes and byte reads on the control block.
 Assumes one clock, inputs sampled on its rising edge.
*/
module pfr_host_model
(
	// Clock and read data
	input wire logic clk_sys_in,
	input wire logic [7:0] rd_data_in,
	// Byte port drive
	output logic wr_en_out,
	output pfr_pkg::pfr_wr_s wr_out,
	output logic [7:0] rd_index_out
);
	timeunit 1ns;
	timeprecision 100ps;
	import pfr_pkg::*;
	initial
	begin
		wr_en_out = 1'b0;
		wr_out = '0;
		rd_index_out = 8'h00;
	end
	// One strobe per byte; bus scrambled when released
	// caller sends N before M
	task automatic wr_byte(input logic [7:0] idx, input logic [7:0] val);
		@(posedge clk_sys_in);
		#1 wr_en_out = 1'b1;
		wr_out = '{index: idx, data: val};
		@(posedge clk_sys_in);
		#1 wr_en_out = 1'b0;
		wr_out = ~wr_out;
	endtask : wr_byte
	// Read data lands one edge after the index
	task automatic rd_byte(input logic [7:0] idx, output logic [7:0] val);
		@(posedge clk_sys_in);
		#1 rd_index_out = idx;
		@(posedge clk_sys_in);
		#1 val = rd_data_in;
	endtask : rd_byte
endmodule : pfr_host_model

// file: pfr_map.svh
/*
 Constants for the programmable and recovery frequency control bytes:
 byte indexes, field positions, reset values and pulse timing.
 Assumes it is included by its bare name from the design.
*/
`ifndef PFR_MAP_SVH
`define PFR_MAP_SVH

// ----------------------------------------
// Byte indexes on the management byte port
// ----------------------------------------
`define PFR_IDX_RECOV_SRC_M 8'h0c
`define PFR_IDX_RECOV_N 8'h0b
`define PFR_IDX_PROG_N 8'h0d
`define PFR_IDX_PROG_EN_M 8'h0e

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PFR_BIT_RECOV_SRC 7
`define PFR_BIT_CUSTOM_EN 7
`define PFR_M_MSB 6

// ----------------------------------------
// Power-on values
// ----------------------------------------
`define PFR_RST_BYTE 8'h00

// ----------------------------------------
// Load strobe length in clock cycles
// ----------------------------------------
`define PFR_LOAD_PULSE_CYC 1

`endif

// file: pfr_pkg.sv
/*
 Types shared by the frequency control block and its bench.
 Assumes pfr_map.svh is on the include path.
*/
package pfr_pkg;

	// ----------------------------------------
	// Mode of the frequency selection
	// ----------------------------------------
	typedef enum logic {
		PFR_NORMAL,
		PFR_RECOVERY
	} pfr_mode_e;

	// ----------------------------------------
	// Byte write request
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] index; // Byte index
		logic [7:0] data; // Byte value
	} pfr_wr_s;

	// ----------------------------------------
	// Selection handed to the synthesizer
	// ----------------------------------------
	typedef struct packed {
		logic use_divider; // 1: N/M words, 0: table code
		logic [7:0] n_word; // Feedback divider word
		logic [6:0] m_word; // Reference divider word
		logic [4:0] freq_code; // Table frequency code
		logic [4:0] ratio_code; // Output ratio code
	} pfr_freq_s;

endpackage : pfr_pkg

// file: tb_top.sv
/*
 Self-checking bench for the frequency control block.
 Assumes pfr_pkg, pfr_ctrl and pfr_host_model are compiled first.
*/
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import pfr_pkg::*;
	logic clk_sys_in = 1'b0;
	logic srst_in = 1'b1;
	logic wr_en_in;
	pfr_wr_s wr_in;
	logic [7:0] rd_index_in, rd_data_out, rb;
	logic [4:0] strap = 5'h0a, sw = 5'h15;
	logic ovr = 1'b0, arm = 1'b0, wdt = 1'b0;
	pfr_freq_s freq_out;
	logic load_out, recovery_mode_out;
	int err_total = 0;
	int check_count = 0;
	always #2 clk_sys_in = ~clk_sys_in;
	pfr_ctrl pfr_ctrl_i (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .wr_en_in(wr_en_in),
		.wr_in(wr_in), .rd_index_in(rd_index_in), .rd_data_out(rd_data_out),
		.latched_strap_ratio_code_in(strap), .sw_ratio_code_in(sw),
		.ratio_source_override_in(ovr), .watchdog_arm_bit_in(arm), .wd_timeout_in(wdt),
		.freq_out(freq_out), .load_out(load_out), .recovery_mode_out(recovery_mode_out));
	pfr_host_model pfr_host_model_i (.clk_sys_in(clk_sys_in), .rd_data_in(rd_data_out),
		.wr_en_out(wr_en_in), .wr_out(wr_in), .rd_index_out(rd_index_in));
	// Case-equal compare, counted
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	// Timeout pulse, outputs looked at after the taking edge
	task automatic fire_timeout;
		@(posedge clk_sys_in);
		#1 wdt = 1'b1;
		@(posedge clk_sys_in);
		#1 wdt = 1'b0;
	endtask : fire_timeout
	task automatic t_reset_bytes;
		for (int i = 8'h0b; i <= 8'h0e; i++)
		begin
			pfr_host_model_i.rd_byte(8'(i), rb);
			chk("reset byte", 32'h00, 32'(rb));
		end
	endtask : t_reset_bytes
	task automatic t_program;
		pfr_host_model_i.wr_byte(8'h0d, 8'h5a);
		chk("load on N", 32'h0, 32'(load_out));
		pfr_host_model_i.wr_byte(8'h0e, 8'h85);
		chk("load on M", 32'h1, 32'(load_out));
		chk("prog words", 32'had05, 32'({freq_out.use_divider, freq_out.n_word,
			freq_out.m_word}));
		pfr_host_model_i.rd_byte(8'h0d, rb);
		chk("prog N read", 32'h5a, 32'(rb));
		pfr_host_model_i.wr_byte(8'h0e, 8'h05);
		chk("custom off", 32'h0, 32'(freq_out.use_divider));
		chk("ratio strap", 32'h0a, 32'(freq_out.ratio_code));
		@(posedge clk_sys_in);
		#1 ovr = 1'b1;
		@(posedge clk_sys_in);
		#1 chk("ratio sw", 32'h15, 32'(freq_out.ratio_code));
	endtask : t_program
	task automatic t_recovery;
		pfr_host_model_i.wr_byte(8'h0b, 8'h33);
		pfr_host_model_i.wr_byte(8'h0c, 8'h91);
		pfr_host_model_i.rd_byte(8'h0c, rb);
		chk("src byte", 32'h91, 32'(rb));
		fire_timeout();
		chk("disarmed", 32'h0, 32'(recovery_mode_out));
		arm = 1'b1;
		fire_timeout();
		chk("rec mode", 32'h1, 32'(recovery_mode_out));
		chk("rec load", 32'h1, 32'(load_out));
		chk("rec words", 32'h9991, 32'({freq_out.use_divider, freq_out.n_word,
			freq_out.m_word}));
		pfr_host_model_i.wr_byte(8'h0e, 8'h87);
		chk("locked load", 32'h0, 32'(load_out));
		pfr_host_model_i.rd_byte(8'h0e, rb);
		chk("locked byte", 32'h05, 32'(rb));
		pfr_host_model_i.wr_byte(8'h0c, 8'h00);
		chk("locked words", 32'h9991, 32'({freq_out.use_divider, freq_out.n_word,
			freq_out.m_word}));
		@(posedge clk_sys_in);
		#1 arm = 1'b0;
		@(posedge clk_sys_in);
		#1 chk("unlock", 32'h0, 32'(recovery_mode_out));
		arm = 1'b1;
		fire_timeout();
		chk("strap src", 32'h00a, 32'({freq_out.use_divider, freq_out.freq_code}));
	endtask : t_recovery
	// Run well past the expected few dozen cycles
	initial
	begin
		#20000;
		err_total++;
		tally_and_finish();
	end
	initial
	begin
		repeat (4) @(posedge clk_sys_in);
		#1 srst_in = 1'b0;
		t_reset_bytes();
		t_program();
		t_recovery();
		tally_and_finish();
	end
endmodule : tb_top
